// ===== bench/bus_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model #(
  parameter int HALF = 16
) (
  input  wire logic       lclk,
  input  wire logic       sda_in,
  output logic            scl,
  output logic            pull_low,
  output logic            got,
  output logic      [7:0] got_val
);
  // Idle bus: the clock stands high and data is left to the pull-up.
  initial begin
    scl      = 1'b1;
    pull_low = 1'b0;
    got      = 1'b0;
    got_val  = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  task automatic report(input logic [7:0] v);
    got     <= 1'b1;
    got_val <= v;
    tick(1);
    got     <= 1'b0;
  endtask : report

  //////////////////////////////////////////////////////////////////////////
  task automatic start_cond();
    pull_low <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    pull_low <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b0;
    tick(HALF / 2);
  endtask : start_cond

  task automatic stop_cond();
    pull_low <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    pull_low <= 1'b0;
    tick(HALF);
  endtask : stop_cond

  // Data moves only while the clock is low, so the target never sees a
  // false start or stop in mid-byte.
  task automatic clock_bit(input logic b, output logic s);
    pull_low <= ~b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    s = sda_in;
    tick(HALF / 2);
    scl <= 1'b0;
    tick(HALF / 2);
  endtask : clock_bit

  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(v[i], s);
    end
    clock_bit(1'b1, s);
    report({7'h00, s});
  endtask : put_byte

  task automatic get_byte(input logic ack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      v[i] = s;
    end
    clock_bit(~ack, s);
    report(v);
  endtask : get_byte
endmodule : bus_controller_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PROG = 600;
  logic       ref_clk;
  logic       lclk;
  logic       rst_n;
  logic       wp;
  logic [2:0] straps;
  logic       sda_o;
  logic       sda_oe;
  logic       program_busy;
  logic       scl;
  logic       pull_low;
  logic       got;
  logic [7:0] got_val;
  logic       sda_wire;
  int         num_errors;
  int         checked;
  int         seed;
  int         busy_cnt;
  logic [7:0] exp_q[$];
  logic [7:0] page_d[4];

  // The wire is low if either party pulls it, else the pull-up wins.
  assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~pull_low;

  serial_eeprom_i2c_target #(.PROG_CYCLES(PROG)) dut (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .scl          (scl),
    .sda_i        (sda_wire),
    .sda_o        (sda_o),
    .sda_oe       (sda_oe),
    .wp           (wp),
    .strap_bit0   (straps[0]),
    .strap_bit1   (straps[1]),
    .strap_bit2   (straps[2]),
    .program_busy (program_busy)
  );

  bus_controller_model u_ctl (
    .lclk     (lclk),
    .sda_in   (sda_wire),
    .scl      (scl),
    .pull_low (pull_low),
    .got      (got),
    .got_val  (got_val)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  always @(posedge lclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("bus result", {8'h00, got_val}, 16'hFFFF);
      end else begin
        check("bus result", {8'h00, got_val}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  // Programming time is counted here so a shortened or lengthened cycle shows.
  always @(posedge ref_clk) begin
    if (program_busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end else if (busy_cnt != 0) begin
      check("busy length", 16'(busy_cnt), 16'(PROG));
      busy_cnt <= 0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic dev(input logic dir, input logic [2:0] s, input logic [7:0] a);
    exp_q.push_back(a);
    u_ctl.start_cond();
    u_ctl.put_byte({4'hA, s, dir});
  endtask : dev

  task automatic aim(input logic [15:0] a);
    dev(1'b0, straps, 8'h00);
    exp_q.push_back(8'h00);
    u_ctl.put_byte(a[15:8]);
    exp_q.push_back(8'h00);
    u_ctl.put_byte(a[7:0]);
  endtask : aim

  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] ack);
    aim(a);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ack);
      u_ctl.put_byte(page_d[i]);
    end
    u_ctl.stop_cond();
  endtask : wr

  task automatic settle_prog();
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk);
    check("busy after stop", {15'h0000, program_busy}, 16'h0001);
    dev(1'b0, straps, 8'h01);
    u_ctl.stop_cond();
    while (program_busy !== 1'b0 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 4000) begin
      check("busy wait", 16'h0000, 16'h0001);
      close_out();
    end
    dev(1'b0, straps, 8'h00);
    u_ctl.stop_cond();
  endtask : settle_prog

  task automatic rd(input logic [15:0] a, input logic sel, input int n,
                    input logic [7:0] e[4]);
    if (sel) begin
      aim(a);
    end
    dev(1'b1, straps, 8'h00);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      u_ctl.get_byte(i < n - 1);
    end
    u_ctl.stop_cond();
  endtask : rd

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge ref_clk);
    check("run time", 16'h0000, 16'h0001);
    close_out();
  end

  initial begin
    seed       = 90243;
    num_errors = 0;
    checked    = 0;
    busy_cnt   = 0;
    rst_n      = 1'b0;
    wp         = 1'b0;
    straps     = 3'h0;
    repeat (12) @(posedge ref_clk);
    rst_n  <= 1'b1;
    straps <= 3'($random(seed));
    for (int i = 0; i < 4; i++) begin
      page_d[i] = 8'($random(seed));
    end
    repeat (10) @(posedge ref_clk);
    check("idle outputs", {14'h0000, sda_oe, program_busy}, 16'h0000);
    dev(1'b0, straps ^ 3'h5, 8'h01);
    u_ctl.stop_cond();
    // The top address bits are set on purpose; they must be ignored.
    wr(16'hE000, 1, 8'h00);
    settle_prog();
    rd(16'h1FFF, 1'b1, 2, '{8'hFF, page_d[0], 8'h00, 8'h00});
    wr(16'h005E, 4, 8'h00);
    settle_prog();
    rd(16'h0040, 1'b1, 2, '{page_d[2], page_d[3], 8'h00, 8'h00});
    rd(16'h0000, 1'b0, 1, '{8'hFF, 8'h00, 8'h00, 8'h00});
    rd(16'h005E, 1'b1, 2, '{page_d[0], page_d[1], 8'h00, 8'h00});
    @(posedge ref_clk);
    wp <= 1'b1;
    wr(16'h0100, 1, 8'h01);
    @(posedge ref_clk);
    wp <= 1'b0;
    rd(16'h0100, 1'b1, 1, '{8'hFF, 8'h00, 8'h00, 8'h00});
    repeat (4) @(posedge lclk);
    check("pending results", 16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// ===== rtl/eeprom_mem.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_ff
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // The erased state is preset here because an array this size has no reset.
  initial begin
    for (int i = 0; i < (1<<AW); i++) begin
      mem[i] = eeprom_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end

endmodule : eeprom_mem
`default_nettype wire

// ===== rtl/eeprom_pkg.sv
// Notes on behaviour
// - Bits are sampled on clock rise; the device changes its data bit after a fall.
// - The device sends only by pulling data low or releasing it.
// - Low is driven, high is released; only the controller drives the clock.
// - Data falling while clock high is START; nothing counts before a START.
// - Data rising while clock high is STOP and ends every command.
// - Respond only to a first byte of prefix 1010 plus the three strap levels.
// - Lowest bit of the first byte selects read when 1, write when 0.
// - In the ninth clock the receiver pulls data low to acknowledge.
// - Byte write: address byte, two memory address bytes, one data byte, each acknowledged.
// - STOP after a write starts programming; meanwhile nothing is acknowledged or driven.
// - Further data bytes of a write fill a 32-byte page buffer from the given address.
// - Page part of the address stays fixed; the in-page offset wraps and overwrites.
// - All buffered bytes are programmed together in one cycle after the STOP.
// - Write protect sampled before the first data byte; high refuses that byte and write.
// - The array holds FFh in every byte at start.
// - A read-direction address byte is acknowledged, then the current byte is sent.
// - Bytes keep coming while the controller acknowledges; NACK then STOP ends it.
// - Sequential reads increment the address and wrap from the top to zero.
package eeprom_pkg;

  localparam int ADDR_W     = 13;
  localparam int PAGE_OFS_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int DATA_W     = 8;

  localparam logic [3:0] DEV_PREFIX = 4'hA;
  localparam logic [3:0] BIT_LAST   = 4'h8;
  localparam logic [3:0] BIT_FIRST  = 4'h1;

  localparam logic [1:0] IDX_DEV  = 2'h0;
  localparam logic [1:0] IDX_HI   = 2'h1;
  localparam logic [1:0] IDX_LO   = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;

  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  localparam int REF_CLK_MHZ              = 25;
  localparam int INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_US * REF_CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } bus_state_t;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] strap;
  } pin_t;

endpackage : eeprom_pkg

// ===== rtl/serial_eeprom_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target #(
  parameter int PROG_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic wp,
  input  wire logic strap_bit0,
  input  wire logic strap_bit1,
  input  wire logic strap_bit2,
  output logic      program_busy
);

  localparam int AW    = eeprom_pkg::ADDR_W;
  localparam int OW    = eeprom_pkg::PAGE_OFS_W;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  if (PROG_CYCLES <= eeprom_pkg::PAGE_BYTES) begin : g_bad_prog
    $error("PROG_CYCLES must exceed the page size");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  logic [1:0] rst_sync_ff;
  logic       rst_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_s = rst_sync_ff[1];

  eeprom_pkg::pin_t pin_in;
  eeprom_pkg::pin_t sync1_ff;
  eeprom_pkg::pin_t sync2_ff;
  eeprom_pkg::pin_t prev_ff;

  assign pin_in = {scl, sda_i, wp, strap_bit2, strap_bit1, strap_bit0};

  // Oversampling the bus keeps START and STOP, which are data edges while
  // the clock is high, in the same domain as ordinary bits.
  // The bus lines reset to their idle high level so no false edge follows.
  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      sync1_ff <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      sync2_ff <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      prev_ff  <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = sync2_ff.scl & ~prev_ff.scl;
  assign scl_fall = ~sync2_ff.scl & prev_ff.scl;
  assign start_ev = sync2_ff.scl & prev_ff.scl & prev_ff.sda & ~sync2_ff.sda;
  assign stop_ev  = sync2_ff.scl & prev_ff.scl & ~prev_ff.sda & sync2_ff.sda;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state.
  function automatic logic dev_match(input logic [7:0] b,
                                     input logic [2:0] s);
    return (b[7:4] == eeprom_pkg::DEV_PREFIX) && (b[3:1] == s);
  endfunction : dev_match

  eeprom_pkg::bus_state_t st_ff;
  logic [3:0]             bit_cnt_ff;
  logic [7:0]             shift_ff;
  logic [1:0]             byte_idx_ff;
  logic                   rw_ff;
  logic                   wp_lat_ff;
  logic                   mack_ok_ff;
  logic [AW-1:0]          addr_ff;
  logic [7:0]             tx_sh_ff;
  logic [7:0]             pbuf_ff [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] pvalid_ff;
  logic                   busy_ff;
  logic [CNT_W-1:0]       prog_cnt_ff;
  logic [7:0]             mem_rdata;

  logic byte_rx;
  logic match;
  logic take_byte;
  logic wp_reject;
  logic tx_load;
  logic prog_done;
  logic first_data;

  assign byte_rx   = (st_ff == eeprom_pkg::ST_RX) && scl_fall &&
                     (bit_cnt_ff == eeprom_pkg::BIT_LAST);
  assign match     = dev_match(shift_ff, sync2_ff.strap) && !busy_ff;
  assign wp_reject = byte_rx && (byte_idx_ff == eeprom_pkg::IDX_DATA) &&
                     wp_lat_ff;
  assign take_byte = byte_rx && !wp_reject &&
                     ((byte_idx_ff != eeprom_pkg::IDX_DEV) || match);
  assign tx_load   = scl_fall &&
                     (((st_ff == eeprom_pkg::ST_ACK) && rw_ff) ||
                      ((st_ff == eeprom_pkg::ST_MACK) && mack_ok_ff));
  assign prog_done = busy_ff && (prog_cnt_ff == CNT_W'(PROG_CYCLES - 1));
  assign first_data = (byte_idx_ff == eeprom_pkg::IDX_DATA) && !(|pvalid_ff);

  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      st_ff       <= eeprom_pkg::ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      byte_idx_ff <= eeprom_pkg::IDX_DEV;
      rw_ff       <= 1'b0;
    end else if (start_ev) begin
      st_ff       <= eeprom_pkg::ST_RX;
      bit_cnt_ff  <= 4'h0;
      byte_idx_ff <= eeprom_pkg::IDX_DEV;
      rw_ff       <= 1'b0;
    end else if (stop_ev) begin
      st_ff <= eeprom_pkg::ST_IDLE;
    end else begin
      case (st_ff)
        eeprom_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_ff < eeprom_pkg::BIT_LAST) begin
            shift_ff   <= {shift_ff[6:0], sync2_ff.sda};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_rx) begin
            // A foreign address or a protected write drops off the bus.
            st_ff <= take_byte ? eeprom_pkg::ST_ACK : eeprom_pkg::ST_IDLE;
            if (byte_idx_ff == eeprom_pkg::IDX_DEV) begin
              rw_ff <= shift_ff[0];
            end
            if (byte_idx_ff != eeprom_pkg::IDX_DATA) begin
              byte_idx_ff <= byte_idx_ff + 2'h1;
            end
          end
        end
        eeprom_pkg::ST_ACK: begin
          if (scl_fall) begin
            st_ff      <= rw_ff ? eeprom_pkg::ST_TX : eeprom_pkg::ST_RX;
            bit_cnt_ff <= rw_ff ? eeprom_pkg::BIT_FIRST : 4'h0;
          end
        end
        eeprom_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == eeprom_pkg::BIT_LAST) begin
              st_ff <= eeprom_pkg::ST_MACK;
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        eeprom_pkg::ST_MACK: begin
          if (scl_fall) begin
            st_ff      <= mack_ok_ff ? eeprom_pkg::ST_TX : eeprom_pkg::ST_IDLE;
            bit_cnt_ff <= eeprom_pkg::BIT_FIRST;
          end
        end
        default: begin
          st_ff <= eeprom_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Controller answer and write protect are caught on their own edges.
  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      mack_ok_ff <= 1'b0;
      wp_lat_ff  <= 1'b0;
    end else begin
      if ((st_ff == eeprom_pkg::ST_MACK) && scl_rise) begin
        mack_ok_ff <= ~sync2_ff.sda;
      end
      if ((st_ff == eeprom_pkg::ST_ACK) && scl_fall && !rw_ff && first_data) begin
        wp_lat_ff <= sync2_ff.wp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address pointer.
  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      addr_ff <= '0;
    end else if (take_byte && byte_idx_ff == eeprom_pkg::IDX_HI) begin
      addr_ff[AW-1:8] <= shift_ff[AW-9:0];
    end else if (take_byte && byte_idx_ff == eeprom_pkg::IDX_LO) begin
      addr_ff[7:0] <= shift_ff;
    end else if (take_byte && byte_idx_ff == eeprom_pkg::IDX_DATA) begin
      addr_ff[OW-1:0] <= addr_ff[OW-1:0] + OW'(1);
    end else if (tx_load) begin
      addr_ff <= addr_ff + AW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer and programming cycle.
  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      pvalid_ff <= '0;
    end else if (prog_done || wp_reject ||
                 (take_byte && byte_idx_ff == eeprom_pkg::IDX_LO)) begin
      pvalid_ff <= '0;
    end else if (take_byte && byte_idx_ff == eeprom_pkg::IDX_DATA) begin
      pvalid_ff[addr_ff[OW-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (take_byte && byte_idx_ff == eeprom_pkg::IDX_DATA) begin
      pbuf_ff[addr_ff[OW-1:0]] <= shift_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      busy_ff     <= 1'b0;
      prog_cnt_ff <= '0;
    end else if (prog_done) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      prog_cnt_ff <= prog_cnt_ff + CNT_W'(1);
    end else if (stop_ev && (|pvalid_ff)) begin
      busy_ff     <= 1'b1;
      prog_cnt_ff <= '0;
    end
  end

  logic           mem_we;
  logic [OW-1:0]  prog_ofs;
  logic [AW-1:0]  mem_addr;

  assign prog_ofs = prog_cnt_ff[OW-1:0];
  assign mem_we   = busy_ff && (prog_cnt_ff < CNT_W'(eeprom_pkg::PAGE_BYTES)) &&
                    pvalid_ff[prog_ofs];
  assign mem_addr = busy_ff ? {addr_ff[AW-1:OW], prog_ofs} : addr_ff;

  eeprom_mem #(
    .AW (AW),
    .DW (eeprom_pkg::DATA_W)
  ) u_mem (
    .clk      (ref_clk),
    .we       (mem_we),
    .addr     (mem_addr),
    .wdata    (pbuf_ff[prog_ofs]),
    .rdata_ff (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data line driver.
  // The line is only ever pulled low, so the output value is a constant
  // and the enable alone carries the bit.
  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      sda_o    <= 1'b0;
      sda_oe   <= 1'b0;
      tx_sh_ff <= 8'h00;
    end else begin
      sda_o <= 1'b0;
      if (start_ev || stop_ev) begin
        sda_oe <= 1'b0;
      end else if (take_byte) begin
        sda_oe <= 1'b1;
      end else if (tx_load) begin
        tx_sh_ff <= mem_rdata;
        sda_oe   <= ~mem_rdata[7];
      end else if ((st_ff == eeprom_pkg::ST_TX) && scl_fall) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
        sda_oe   <= (bit_cnt_ff == eeprom_pkg::BIT_LAST) ? 1'b0 : ~tx_sh_ff[6];
      end else if ((st_ff == eeprom_pkg::ST_ACK) && scl_fall) begin
        sda_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s) begin
    if (!rst_s) begin
      program_busy <= 1'b0;
    end else begin
      // The flag drops on the same edge as the cycle ends, so it stands
      // for exactly the programming length.
      program_busy <= busy_ff ? !prog_done : (stop_ev & (|pvalid_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_s);

  sequence s_dev_miss;
    byte_rx && (byte_idx_ff == eeprom_pkg::IDX_DEV) && !match;
  endsequence
  sequence s_write_close;
    stop_ev && (|pvalid_ff) && !busy_ff;
  endsequence

  property p_oe_after_fall;
    $changed(sda_oe) |-> $past(scl_fall || start_ev || stop_ev);
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("data enable moved outside a clock fall");

  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data output not held low");

  property p_idle_until_start;
    (st_ff == eeprom_pkg::ST_IDLE) && !start_ev |=> st_ff == eeprom_pkg::ST_IDLE;
  endproperty
  a_idle_until_start: assert property (p_idle_until_start)
    else $error("left idle without a start");

  property p_stop_ends;
    stop_ev |=> (st_ff == eeprom_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_stop_ends: assert property (p_stop_ends)
    else $error("stop did not end the command");

  property p_dev_miss;
    s_dev_miss |=> (st_ff == eeprom_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_dev_miss: assert property (p_dev_miss)
    else $error("foreign address answered");

  property p_ack_drives;
    take_byte |=> sda_oe throughout (st_ff == eeprom_pkg::ST_ACK)[*2];
  endproperty
  a_ack_drives: assert property (p_ack_drives)
    else $error("acknowledge not driven");

  property p_busy_quiet;
    busy_ff |-> !sda_oe && (st_ff != eeprom_pkg::ST_ACK);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("bus answered while programming");

  property p_prog_start;
    s_write_close |=> busy_ff && program_busy && (prog_cnt_ff == '0);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("programming not started by stop");

  property p_page_wrap;
    take_byte && (byte_idx_ff == eeprom_pkg::IDX_DATA) |=>
      (addr_ff[AW-1:OW] == $past(addr_ff[AW-1:OW])) &&
      (addr_ff[OW-1:0] == $past(addr_ff[OW-1:0]) + OW'(1));
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page address moved during page write");

  property p_wp_reject;
    wp_reject |=> (st_ff == eeprom_pkg::ST_IDLE) && (pvalid_ff == '0) && !sda_oe;
  endproperty
  a_wp_reject: assert property (p_wp_reject)
    else $error("protected write was accepted");

  property p_read_incr;
    tx_load |=> (addr_ff == $past(addr_ff) + AW'(1)) &&
                (tx_sh_ff == $past(mem_rdata));
  endproperty
  a_read_incr: assert property (p_read_incr)
    else $error("read address did not advance");

endmodule : serial_eeprom_i2c_target
`default_nettype wire
